//--- rtl/pcu_params.svh
// Offsets, field positions, reset values and timing for the capture unit.
`ifndef PCU_PARAMS_SVH
`define PCU_PARAMS_SVH
`define PCU_ADDR_W       8
`define PCU_OFF_CTRL     8'h00
`define PCU_OFF_CFG      8'h04
`define PCU_OFF_START    8'h08
`define PCU_OFF_COUNT    8'h0C
`define PCU_OFF_AXPOS    8'h10
`define PCU_OFF_RELRST   8'h14
`define PCU_OFF_GAP      8'h18
`define PCU_OFF_INFN     8'h1C
`define PCU_OFF_STAT     8'h20
`define PCU_OFF_DPTR     8'h24
`define PCU_OFF_DATA     8'h28
`define PCU_CTRL_EN      0
`define PCU_CTRL_REL     1
`define PCU_CTRL_CMP     2
`define PCU_CTRL_PATH    3
`define PCU_CFG_SRC_LO   0
`define PCU_CFG_SRC_HI   1
`define PCU_CFG_POL      2
`define PCU_INFN_FORCED  16'h0100
`define PCU_INFN_DEFAULT 16'h0000
`define PCU_PATH_NUM     8'h32
`define PCU_ARRAY_DEPTH  800
`define PCU_CLK_NS       20
`define PCU_LATCH_MAX_NS 1000
`define PCU_LATCH_CYC    (`PCU_LATCH_MAX_NS / `PCU_CLK_NS)
`endif

//--- rtl/pcu_pkg.sv
// Types shared by the capture unit modules.
`default_nettype none
package pcu_pkg;
  typedef enum logic [1:0] {
    PCU_IDLE  = 2'b01,
    PCU_ARMED = 2'b10
  } pcu_state_t;
  typedef enum logic [1:0] {
    PCU_SRC_MOTOR = 2'h0,
    PCU_SRC_SCALE = 2'h1,
    PCU_SRC_PULSE = 2'h2
  } pcu_src_t;
endpackage : pcu_pkg
`default_nettype wire

//--- rtl/pcu_mem_if.sv
// Port bundle between the capture logic and its data array.
`default_nettype none
interface pcu_mem_if #(parameter int AW = 10, parameter int DW = 32);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport owner (output we, waddr, wdata, raddr, input rdata);
  modport store (input we, waddr, wdata, raddr, output rdata);
endinterface : pcu_mem_if
`default_nettype wire

//--- rtl/pcu_array.sv
// Shared position data array with a registered read port.
`default_nettype none
module pcu_array
  import pcu_pkg::*;
#(
  parameter int DEPTH = 800
)(
  input wire logic  clk_in, // Block clock.
  pcu_mem_if.store  mem     // Write and read port.
);
  logic [31:0] ram [0:DEPTH-1];

  always_ff @(posedge clk_in)
  begin
    if (mem.we)
    begin
      ram[mem.waddr] <= mem.wdata;
    end
    mem.rdata <= ram[mem.raddr];
  end
endmodule : pcu_array
`default_nettype wire

//--- rtl/pcu_top.sv
// Position capture unit: trigger, indexing, options and register port.
//
// Behaviour
// - Capture axis selectable: encoder, scale, pulses.
// - Source change refused while compare uses it.
// - Trigger latches position within one microsecond.
// - Enable forces input function config to 0x0100.
// - Forced config volatile; reset restores default.
// - Edge trigger, normally open or closed polarity.
// - Triggers ignored until minimum interval passes.
// - First value stored at start index.
// - Positions stored as signed 32-bit counts.
// - Relative bit reloads axis after first point.
// - Compare bit starts compare after first point.
// - Path bit calls procedure 50 at end.
// - All auxiliary options default off.
// - Done on last point, cleared on enable.
// - Enable with zero count disables, done off.
// - Writing enable bit one starts capture.
// - One point per trigger at next entry.
// - Remaining count decrements, stops at zero.
// - Completion clears enable and raises done.
// - Relative: first value reload, then movement.
// - Absolute mode stores axis plus offset kept from relative runs.
`include "pcu_params.svh"
`default_nettype none
module pcu_top
  import pcu_pkg::*;
#(
  parameter int AW    = 10,
  parameter int DEPTH = `PCU_ARRAY_DEPTH
)(
  input  wire logic          ref_clk_in,             // 50 MHz clock.
  input  wire logic          rst_in,                 // Sync reset, high.
  input  wire logic [7:0]    reg_addr_in,            // Register offset.
  input  wire logic [31:0]   reg_wdata_in,           // Write data.
  input  wire logic          reg_wr_in,              // Write strobe.
  input  wire logic          reg_rd_in,              // Read strobe.
  output logic      [31:0]   reg_rdata_out,          // Read data.
  input  wire logic          fast_capture_input_in,  // Trigger pin.
  input  wire logic [31:0]   motor_pos_in,           // Encoder axis.
  input  wire logic [31:0]   scale_pos_in,           // Linear scale axis.
  input  wire logic [31:0]   pulse_pos_in,           // Pulse train axis.
  input  wire logic          compare_on_capture_in,  // Compare uses axis.
  output logic               capture_done_output_out, // Done level.
  output logic               compare_start_out,      // Compare pulse.
  output logic               path_call_out,          // Path call pulse.
  output logic      [7:0]    path_number_out,        // Called path.
  output logic      [15:0]   input_function_config_out, // Input config.
  output logic               infn_volatile_out       // Do not persist.
);
  localparam int LATCH_CYC = `PCU_LATCH_CYC;

  pcu_state_t    state;
  pcu_state_t    next_state;
  pcu_src_t      src;
  logic          pol;
  logic [3:1]    opt;
  logic [AW-1:0] start_idx;
  logic [AW-1:0] count;
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] dptr;
  logic [31:0]   relrst;
  logic [31:0]   pos_offset;
  logic [15:0]   gap_len;
  logic [15:0]   gap_cnt;
  logic          first_pt;
  logic          trig_prev;

  pcu_mem_if #(.AW(AW), .DW(32)) mem ();

  pcu_array #(.DEPTH(DEPTH)) u_array (
    .clk_in (ref_clk_in),
    .mem    (mem)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  logic        wr_ctrl;
  logic        wr_cfg;
  logic        wr_start;
  logic        wr_count;
  logic        wr_relrst;
  logic        wr_gap;
  logic        wr_infn;
  logic        wr_dptr;
  logic        wr_data;
  logic        en_req;
  logic        armed;
  logic [31:0] sel_pos;
  logic [31:0] axis_pos;
  logic        trig_level;
  logic        trig_edge;
  logic        gap_busy;
  logic        accept;
  logic        last;
  logic [31:0] store_val;
  logic [31:0] rd_mux;

  assign wr_ctrl   = reg_wr_in & hit(reg_addr_in, `PCU_OFF_CTRL);
  assign wr_cfg    = reg_wr_in & hit(reg_addr_in, `PCU_OFF_CFG);
  assign wr_start  = reg_wr_in & hit(reg_addr_in, `PCU_OFF_START);
  assign wr_count  = reg_wr_in & hit(reg_addr_in, `PCU_OFF_COUNT);
  assign wr_relrst = reg_wr_in & hit(reg_addr_in, `PCU_OFF_RELRST);
  assign wr_gap    = reg_wr_in & hit(reg_addr_in, `PCU_OFF_GAP);
  assign wr_infn   = reg_wr_in & hit(reg_addr_in, `PCU_OFF_INFN);
  assign wr_dptr   = reg_wr_in & hit(reg_addr_in, `PCU_OFF_DPTR);
  assign wr_data   = reg_wr_in & hit(reg_addr_in, `PCU_OFF_DATA);
  assign en_req    = wr_ctrl & reg_wdata_in[`PCU_CTRL_EN];
  assign armed     = (state == PCU_ARMED);

  assign sel_pos  = (src == PCU_SRC_SCALE) ? scale_pos_in :
                    (src == PCU_SRC_PULSE) ? pulse_pos_in : motor_pos_in;
  assign axis_pos = sel_pos + pos_offset;

  assign trig_level = fast_capture_input_in ^ pol;
  assign trig_edge  = trig_level & ~trig_prev;
  assign gap_busy   = (gap_cnt != 16'h0000);

  assign accept = armed & trig_edge & ~gap_busy & (count != '0) & ~wr_ctrl;
  assign last   = accept & (count == AW'(1));

  assign store_val = (first_pt & opt[`PCU_CTRL_REL]) ? relrst : axis_pos;

  assign mem.we    = accept | wr_data;
  assign mem.waddr = accept ? wr_idx : dptr;
  assign mem.wdata = accept ? store_val : reg_wdata_in;
  assign mem.raddr = dptr;

  assign rd_mux =
    hit(reg_addr_in, `PCU_OFF_CTRL)   ? {28'h0, opt, armed} :
    hit(reg_addr_in, `PCU_OFF_CFG)    ? {29'h0, pol, src} :
    hit(reg_addr_in, `PCU_OFF_START)  ? 32'(start_idx) :
    hit(reg_addr_in, `PCU_OFF_COUNT)  ? 32'(count) :
    hit(reg_addr_in, `PCU_OFF_AXPOS)  ? axis_pos :
    hit(reg_addr_in, `PCU_OFF_RELRST) ? relrst :
    hit(reg_addr_in, `PCU_OFF_GAP)    ? {16'h0, gap_len} :
    hit(reg_addr_in, `PCU_OFF_INFN)   ? {16'h0, input_function_config_out} :
    hit(reg_addr_in, `PCU_OFF_STAT)   ?
      {28'h0, compare_on_capture_in, gap_busy,
       capture_done_output_out, armed} :
    hit(reg_addr_in, `PCU_OFF_DPTR)   ? 32'(dptr) :
    hit(reg_addr_in, `PCU_OFF_DATA)   ? mem.rdata : 32'h0000_0000;

  always_comb
  begin
    next_state = state;
    case (state)
      PCU_IDLE:
      begin
        if (en_req && count != '0)
          next_state = PCU_ARMED;
      end
      PCU_ARMED:
      begin
        if (wr_ctrl && !reg_wdata_in[`PCU_CTRL_EN])
          next_state = PCU_IDLE;
        else if (wr_ctrl && count == '0)
          next_state = PCU_IDLE;
        else if (last)
          next_state = PCU_IDLE;
      end
      default:
        next_state = PCU_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      state <= PCU_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      opt <= 3'h0;
    else if (wr_ctrl)
      opt <= reg_wdata_in[`PCU_CTRL_PATH:`PCU_CTRL_REL];
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      src <= PCU_SRC_MOTOR;
      pol <= 1'b0;
    end
    else if (wr_cfg)
    begin
      pol <= reg_wdata_in[`PCU_CFG_POL];
      if (!compare_on_capture_in &&
          reg_wdata_in[`PCU_CFG_SRC_HI:`PCU_CFG_SRC_LO] != 2'h3)
        src <= pcu_src_t'(reg_wdata_in[`PCU_CFG_SRC_HI:`PCU_CFG_SRC_LO]);
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      start_idx <= '0;
      relrst    <= 32'h0000_0000;
      gap_len   <= 16'h0000;
      dptr      <= '0;
    end
    else
    begin
      if (wr_start)
        start_idx <= reg_wdata_in[AW-1:0];
      if (wr_relrst)
        relrst <= reg_wdata_in;
      if (wr_gap)
        gap_len <= reg_wdata_in[15:0];
      if (wr_dptr)
        dptr <= reg_wdata_in[AW-1:0];
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      count <= '0;
    else if (wr_count)
      count <= reg_wdata_in[AW-1:0];
    else if (accept)
      count <= count - AW'(1);
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      wr_idx <= '0;
    else if (en_req)
      wr_idx <= start_idx;
    else if (accept)
      wr_idx <= wr_idx + AW'(1);
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      first_pt <= 1'b0;
    else if (en_req)
      first_pt <= 1'b1;
    else if (accept)
      first_pt <= 1'b0;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      pos_offset <= 32'h0000_0000;
    else if (accept && first_pt && opt[`PCU_CTRL_REL])
      pos_offset <= relrst - sel_pos;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      gap_cnt <= 16'h0000;
    else if (accept)
      gap_cnt <= gap_len;
    else if (gap_busy)
      gap_cnt <= gap_cnt - 16'h0001;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      trig_prev <= 1'b0;
    else
      trig_prev <= trig_level;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      capture_done_output_out <= 1'b0;
    else if (en_req)
      capture_done_output_out <= 1'b0;
    else if (last)
      capture_done_output_out <= 1'b1;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      compare_start_out <= 1'b0;
      path_call_out     <= 1'b0;
      path_number_out   <= 8'h00;
    end
    else
    begin
      compare_start_out <= accept & first_pt & opt[`PCU_CTRL_CMP];
      path_call_out     <= last & opt[`PCU_CTRL_PATH];
      if (last && opt[`PCU_CTRL_PATH])
        path_number_out <= `PCU_PATH_NUM;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      input_function_config_out <= `PCU_INFN_DEFAULT;
      infn_volatile_out         <= 1'b0;
    end
    else if (en_req && count != '0)
    begin
      input_function_config_out <= `PCU_INFN_FORCED;
      infn_volatile_out         <= 1'b1;
    end
    else if (wr_infn && !armed)
    begin
      input_function_config_out <= reg_wdata_in[15:0];
      infn_volatile_out         <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      reg_rdata_out <= 32'h0000_0000;
    else if (reg_rd_in)
      reg_rdata_out <= rd_mux;
    else
      reg_rdata_out <= 32'h0000_0000;
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  a_latch_time: assert property (
    armed && count != '0 && !gap_busy && trig_level && !trig_prev
      && !wr_ctrl |-> ##[0:LATCH_CYC] (mem.we
      && mem.waddr == wr_idx))
    else $error("accepted trigger did not latch");
  a_count_dec: assert property (
    accept && !wr_count |=> count == $past(count) - AW'(1))
    else $error("remaining count did not drop by one");
  a_done_end: assert property (
    last |=> capture_done_output_out && state == PCU_IDLE)
    else $error("completion did not raise done and disarm");
  a_done_clr: assert property (
    en_req |=> !capture_done_output_out)
    else $error("done not cleared by enable");
  a_zero_cnt: assert property (
    en_req && count == '0 |=> state == PCU_IDLE
      && !capture_done_output_out)
    else $error("enable with zero count was not refused");
  a_gap_hold: assert property (
    accept && gap_len != 16'h0000 |=> !accept [*1]
      ##0 gap_cnt == $past(gap_len))
    else $error("interval holdoff not loaded");
  a_idle_ignore: assert property (
    state == PCU_IDLE && !wr_count && !wr_ctrl
      |=> count == $past(count))
    else $error("count moved while disabled");
  a_rel_first: assert property (
    accept && first_pt && opt[`PCU_CTRL_REL]
      |-> mem.wdata == relrst ##1 axis_pos == relrst + sel_pos
      - $past(sel_pos))
    else $error("relative first point wrong");
  a_infn_force: assert property (
    en_req && count != '0 |=>
      input_function_config_out == `PCU_INFN_FORCED)
    else $error("input config not forced");
  a_src_lock: assert property (
    wr_cfg && compare_on_capture_in |=> src == $past(src))
    else $error("source changed while compare uses it");
  a_cmp_start: assert property (
    accept && first_pt && opt[`PCU_CTRL_CMP]
      |=> compare_start_out ##1 !compare_start_out)
    else $error("compare start pulse wrong");
  a_path_call: assert property (
    last && opt[`PCU_CTRL_PATH] |=> path_call_out
      && path_number_out == `PCU_PATH_NUM)
    else $error("path procedure not called");

  c_full_run: cover property (en_req ##[1:200] last);
  c_relative: cover property (accept && first_pt && opt[`PCU_CTRL_REL]);
  c_zero_cnt: cover property (en_req && count == '0);
  c_gap_drop: cover property (armed && trig_edge && gap_busy);
endmodule : pcu_top
`default_nettype wire

//--- testbench/pcu_trig_model.sv
// Far-side model: capture contact and the three position axes.
`default_nettype none
module pcu_trig_model
#(
  parameter int HOLD = 3
)(
  input  wire logic        ref_clk_in, // Block clock.
  input  wire logic        fire_in,    // Request one contact closure.
  input  wire logic        pol_in,     // 1 = normally closed contact.
  output logic             trig_out,   // Contact level at the pin.
  output logic [31:0]      motor_out,  // Encoder axis.
  output logic [31:0]      scale_out,  // Linear scale axis.
  output logic [31:0]      pulse_out   // Pulse train axis.
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned k        = 0;
  int unsigned hold_cnt = 0;
  logic        active;
  assign active    = (hold_cnt != 0);
  // contact polarity: a closed contact idles high and pulls low.
  assign trig_out  = pol_in ^ active;
  assign motor_out = 32'h0000_1000 + 32'(k) * 32'h0000_0010;
  assign scale_out = 32'h8000_0000 + 32'(k) * 32'h0000_0100;
  assign pulse_out = 32'hFFFF_FFF0 - 32'(k) * 32'h0000_0003;
  // Axes move only while the contact is released, so a latch sees one value.
  always @(posedge ref_clk_in)
  begin
    if (fire_in)
      hold_cnt <= HOLD;
    else if (hold_cnt != 0)
    begin
      hold_cnt <= hold_cnt - 1;
      if (hold_cnt == 1)
        k <= k + 1;
    end
  end
endmodule : pcu_trig_model
`default_nettype wire

//--- testbench/test_position_capture_unit.sv
// Self-checking bench for the position capture unit.
`include "pcu_params.svh"
`default_nettype none
`define PCU_CHK(g, e) check_eq(32'(g), 32'(e))
module test_position_capture_unit
  import pcu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk     = 1'b0;
  logic        rst     = 1'b1;
  logic [7:0]  addr    = 8'h00;
  logic [31:0] wdata   = 32'h0000_0000;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic        cmp_use = 1'b0;
  logic        fire    = 1'b0;
  logic        pol     = 1'b0;
  logic [31:0] rdata;
  logic [31:0] mpos;
  logic [31:0] spos;
  logic [31:0] ppos;
  logic        trig;
  logic        done;
  logic        cmp_st;
  logic        path_c;
  logic        vol;
  logic [7:0]  path_n;
  logic [15:0] infn;
  int          n_mismatch = 0;
  int          checked    = 0;
  int          n_cmp      = 0;
  int          n_path     = 0;
  int          nf         = 0;

  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    n_cmp  <= n_cmp + int'(cmp_st === 1'b1);
    n_path <= n_path + int'(path_c === 1'b1);
  end

  pcu_top uut (
    .ref_clk_in(clk), .rst_in(rst), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .fast_capture_input_in(trig),
    .motor_pos_in(mpos), .scale_pos_in(spos), .pulse_pos_in(ppos),
    .compare_on_capture_in(cmp_use), .capture_done_output_out(done),
    .compare_start_out(cmp_st), .path_call_out(path_c),
    .path_number_out(path_n), .input_function_config_out(infn),
    .infn_volatile_out(vol));
  pcu_trig_model far (
    .ref_clk_in(clk), .fire_in(fire), .pol_in(pol), .trig_out(trig),
    .motor_out(mpos), .scale_out(spos), .pulse_out(ppos));

  function automatic logic [31:0] ax(input int s, input int k);
    case (s)
      0: return 32'h0000_1000 + 32'(k) * 32'h0000_0010;
      1: return 32'h8000_0000 + 32'(k) * 32'h0000_0100;
      default: return 32'hFFFF_FFF0 - 32'(k) * 32'h0000_0003;
    endcase
  endfunction : ax

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic check_eq(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check_eq

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd_reg(a, v);
    `PCU_CHK(v, e);
  endtask : chk_reg

  task automatic chk_mem(input int idx, input logic [31:0] e);
    wr_reg(`PCU_OFF_DPTR, 32'(idx));
    chk_reg(`PCU_OFF_DATA, e);
  endtask : chk_mem

  task automatic fire_one();
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    nf++;
    repeat (6) @(posedge clk);
    #1;
  endtask : fire_one

  task automatic settle();
    @(posedge clk);
    #1;
  endtask : settle

  task automatic s_reset();
    chk_reg(`PCU_OFF_CTRL, 32'h0000_0000);
    chk_reg(`PCU_OFF_INFN, 32'h0000_0000);
    chk_reg(8'h30, 32'h0000_0000);
    `PCU_CHK(done, 1'b0);
    `PCU_CHK(path_n, 8'h00);
  endtask : s_reset

  task automatic s_absolute();
    int          k0;
    int          p0;
    logic [31:0] v;
    // start plus count stays inside the array.
    wr_reg(`PCU_OFF_COUNT, 32'h0000_0003);
    wr_reg(`PCU_OFF_START, 32'h0000_0005);
    fire_one();
    chk_reg(`PCU_OFF_COUNT, 32'h0000_0003);
    wr_reg(`PCU_OFF_CTRL, 32'h0000_0009);
    settle();
    `PCU_CHK(infn, `PCU_INFN_FORCED);
    `PCU_CHK(vol, 1'b1);
    k0 = nf;
    p0 = n_path;
    fire_one();
    chk_reg(`PCU_OFF_COUNT, 32'h0000_0002);
    `PCU_CHK(done, 1'b0);
    fire_one();
    fire_one();
    `PCU_CHK(done, 1'b1);
    `PCU_CHK(n_path - p0, 1);
    `PCU_CHK(path_n, `PCU_PATH_NUM);
    rd_reg(`PCU_OFF_CTRL, v);
    `PCU_CHK(v[0], 1'b0);
    chk_reg(`PCU_OFF_COUNT, 32'h0000_0000);
    for (int i = 0; i < 3; i++)
      chk_mem(5 + i, ax(0, k0 + i));
    chk_mem(7, ax(0, k0 + 2));
    chk_reg(`PCU_OFF_AXPOS, ax(0, nf));
  endtask : s_absolute

  task automatic s_zero();
    logic [31:0] v;
    wr_reg(`PCU_OFF_CTRL, 32'h0000_0001);
    settle();
    `PCU_CHK(done, 1'b0);
    rd_reg(`PCU_OFF_CTRL, v);
    `PCU_CHK(v[0], 1'b0);
    wr_reg(`PCU_OFF_INFN, 32'h0000_1234);
    settle();
    `PCU_CHK(infn, 16'h1234);
    `PCU_CHK(vol, 1'b0);
  endtask : s_zero

  task automatic s_holdoff();
    int          k0;
    int          c0;
    logic [31:0] v;
    wr_reg(`PCU_OFF_CFG, 32'h0000_0004 | 32'(PCU_SRC_SCALE));
    pol <= 1'b1;
    chk_reg(`PCU_OFF_AXPOS, ax(1, nf));
    wr_reg(`PCU_OFF_COUNT, 32'h0000_0002);
    wr_reg(`PCU_OFF_START, 32'h0000_0064);
    wr_reg(`PCU_OFF_GAP, 32'h0000_0014);
    wr_reg(`PCU_OFF_CTRL, 32'h0000_0005);
    wr_reg(`PCU_OFF_INFN, 32'h0000_1234);
    settle();
    `PCU_CHK(infn, `PCU_INFN_FORCED);
    chk_reg(`PCU_OFF_STAT, 32'h0000_0001);
    k0 = nf;
    c0 = n_cmp;
    fire_one();
    chk_reg(`PCU_OFF_STAT, 32'h0000_0005);
    fire_one();
    chk_reg(`PCU_OFF_COUNT, 32'h0000_0001);
    `PCU_CHK(n_cmp - c0, 1);
    repeat (25) @(posedge clk);
    fire_one();
    `PCU_CHK(done, 1'b1);
    chk_mem(100, ax(1, k0));
    chk_mem(101, ax(1, k0 + 2));
    @(posedge clk);
    cmp_use <= 1'b1;
    wr_reg(`PCU_OFF_CFG, 32'h0000_0004 | 32'(PCU_SRC_PULSE));
    rd_reg(`PCU_OFF_CFG, v);
    `PCU_CHK(v[1:0], PCU_SRC_SCALE);
    @(posedge clk);
    cmp_use <= 1'b0;
  endtask : s_holdoff

  task automatic s_relative();
    int k0;
    wr_reg(`PCU_OFF_CFG, 32'h0000_0004 | 32'(PCU_SRC_PULSE));
    wr_reg(`PCU_OFF_RELRST, 32'h0000_0077);
    wr_reg(`PCU_OFF_COUNT, 32'h0000_0002);
    wr_reg(`PCU_OFF_START, 32'h0000_00C8);
    wr_reg(`PCU_OFF_GAP, 32'h0000_0000);
    wr_reg(`PCU_OFF_CTRL, 32'h0000_0003);
    k0 = nf;
    fire_one();
    fire_one();
    chk_mem(200, 32'h0000_0077);
    chk_mem(201, 32'h77 + ax(2, k0 + 1) - ax(2, k0));
    chk_reg(`PCU_OFF_AXPOS, 32'h77 + ax(2, nf) - ax(2, k0));
    @(posedge clk);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    settle();
    `PCU_CHK(vol, 1'b0);
    `PCU_CHK(done, 1'b0);
    chk_reg(`PCU_OFF_INFN, 32'(`PCU_INFN_DEFAULT));
  endtask : s_relative

  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    s_reset();
    s_absolute();
    s_zero();
    s_holdoff();
    s_relative();
    tally_and_finish();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule : test_position_capture_unit
`default_nettype wire
